// file: inc/typeb_ac_defs.svh
`ifndef TYPEB_AC_DEFS_SVH
`define TYPEB_AC_DEFS_SVH
// command and answer codes (first byte of a frame)
`define CMD_REQ       8'h05
`define CMD_ATTRIB    8'h1D
`define CMD_HALT      8'h50
`define CMD_DESEL     8'hC2
`define CMD_DESEL_CID 8'hCA
`define RSP_ATQB      8'h50
`define RSP_HALT      8'h00
`define SLOT_NIBBLE   4'h5
`define WAKE_BIT      3
`define N_CODE_MAX    3'h4
// frame lengths in bytes, frame check included
`define LEN_REQ       4'h5
`define LEN_SLOT      4'h3
`define LEN_HALT      4'h7
`define LEN_ATTRIB    4'hB
`define LEN_DESEL     4'h3
`define LEN_DESEL_CID 4'h4
`define LEN_MIN       4'h3
`define LEN_MAX       4'hC
// frame check constants, polynomials in bit-reversed form
`define CRC16_PRESET  16'hFFFF
`define CRC16_POLY_R  16'h8408
`define CRC16_RESIDUE 16'hF0B8
`define CRC8_POLY_R   8'h8C
`define PRNG_SEED     16'hACE1
`endif

// file: inc/typeb_ac_pkg.sv
package typeb_ac_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_READY, ST_HALT, ST_ACTIVE} card_t;
  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_CRC} tx_t;
  // received frame as handed to the system domain
  typedef struct packed {
    logic [11:0][7:0] bytes;
    logic [3:0]       len;
    logic             crcOk;
  } rx_frame_t;
  // answer body as handed to the link domain
  typedef struct packed {
    logic [4:0][7:0] bytes;
    logic [2:0]      len;
  } rsp_t;
endpackage

// file: design/typeb_anticollision_crc.sv
`timescale 1ns/1ps
`include "typeb_ac_defs.svh"
module typeb_anticollision_crc (
  input  wire logic        clk_sys,   // system clock, 125 MHz
  input  wire logic        resetn,    // async reset, field power-up
  input  wire logic        linkClk,   // link bit clock
  input  wire logic [31:0] ownPupi,   // card identifier for anticollision
  input  wire logic [7:0]  ownAfi,    // application family of this card
  input  wire logic        rxValid,   // link: received byte valid
  input  wire logic [7:0]  rxData,    // link: received byte
  input  wire logic        rxEnd,     // link: end of received frame
  output logic             txBit,     // link: answer bit, LSb first
  output logic             txActive,  // link: answer bit valid
  input  wire logic        crc8Clear, // clear eight-bit check
  input  wire logic        crc8Shift, // shift one bit into it
  input  wire logic        crc8Bit,   // bit to shift
  output logic [7:0]       crc8Value, // eight-bit check register
  output typeb_ac_pkg::card_t cardState, // card state
  output logic [3:0]       cardCid    // assigned card identifier
);

  ////////////////////////////////////////////////////////////////////////////
  // check helpers

  function automatic logic [15:0] crc16Bit(input logic [15:0] c,
                                           input logic b);
    crc16Bit = (c[0] ^ b) ? ((c >> 1) ^ `CRC16_POLY_R) : (c >> 1);
  endfunction

  function automatic logic [15:0] crc16Byte(input logic [15:0] c,
                                            input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = crc16Bit(r, d[i]);
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link-domain reset: async assert, release after two link edges

  logic lr1Ff;
  logic linkRstN;
  always_ff @(posedge linkClk or negedge resetn)
  begin
    if (!resetn)
    begin
      lr1Ff    <= 1'b0;
      linkRstN <= 1'b0;
    end
    else
    begin
      lr1Ff    <= 1'b1;
      linkRstN <= lr1Ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link receiver: gathers bytes, checks frame, publishes by toggle

  logic [11:0][7:0]        bufFf, nxtBuf;
  logic [3:0]              cntFf, nxtCnt;
  logic [15:0]             rxCrcFf, nxtRxCrc;
  typeb_ac_pkg::rx_frame_t pubFf, nxtPub;
  logic                    reqTogFf, nxtReqTog;

  always_comb
  begin
    nxtBuf    = bufFf;
    nxtCnt    = cntFf;
    nxtRxCrc  = rxCrcFf;
    nxtPub    = pubFf;
    nxtReqTog = reqTogFf;
    if (rxValid)
    begin
      if (cntFf < `LEN_MAX)
        nxtBuf[cntFf] = rxData;
      if (cntFf != 4'hF)
        nxtCnt = cntFf + 4'h1;
      // first byte of a frame starts from the preset
      nxtRxCrc = crc16Byte((cntFf == 4'h0) ? `CRC16_PRESET : rxCrcFf,
                           rxData);
    end
    if (rxEnd)
    begin
      nxtPub.bytes = bufFf;
      nxtPub.len   = cntFf;
      nxtPub.crcOk = (rxCrcFf == `CRC16_RESIDUE) && (cntFf >= `LEN_MIN)
                     && (cntFf <= `LEN_MAX);
      nxtReqTog    = ~reqTogFf;
      nxtCnt       = 4'h0;
    end
  end

  always_ff @(posedge linkClk or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      bufFf    <= '0;
      cntFf    <= 4'h0;
      rxCrcFf  <= `CRC16_PRESET;
      pubFf    <= '0;
      reqTogFf <= 1'b0;
    end
    else
    begin
      bufFf    <= nxtBuf;
      cntFf    <= nxtCnt;
      rxCrcFf  <= nxtRxCrc;
      pubFf    <= nxtPub;
      reqTogFf <= nxtReqTog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // toggle synchronisers, one each way

  logic rq1Ff, rq2Ff, rqSeenFf;
  logic rs1Ff, rs2Ff, rsSeenFf;
  logic rspTogFf, nxtRspTog;
  logic newFrame;
  logic newRsp;
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      {rq1Ff, rq2Ff, rqSeenFf} <= 3'h0;
    else
      {rq1Ff, rq2Ff, rqSeenFf} <= {reqTogFf, rq1Ff, rq2Ff};
  end
  always_ff @(posedge linkClk or negedge linkRstN)
  begin
    if (!linkRstN)
      {rs1Ff, rs2Ff, rsSeenFf} <= 3'h0;
    else
      {rs1Ff, rs2Ff, rsSeenFf} <= {rspTogFf, rs1Ff, rs2Ff};
  end
  assign newFrame = rq2Ff ^ rqSeenFf;
  assign newRsp   = rs2Ff ^ rsSeenFf;

  ////////////////////////////////////////////////////////////////////////////
  // frame decode in the system domain

  logic [7:0] b0;
  logic       ok, isReq, isWake, isSlot, afiHit, pupiHit, open;
  logic       joinReq, slotHit, haltHit, attrHit, deselHit;
  logic [2:0] nCode;
  logic [4:0] nMask, drawR;
  typeb_ac_pkg::card_t stateFf, nxtState;
  logic [4:0]  slotFf, nxtSlot;
  logic [3:0]  cidFf, nxtCid;
  logic [15:0] prngFf, nxtPrng;
  typeb_ac_pkg::rsp_t rspFf, nxtRsp;

  assign b0      = pubFf.bytes[0];
  assign ok      = newFrame && pubFf.crcOk;
  assign isReq   = ok && b0 == `CMD_REQ && pubFf.len == `LEN_REQ;
  assign isWake  = pubFf.bytes[2][`WAKE_BIT];
  assign nCode   = (pubFf.bytes[2][2:0] > `N_CODE_MAX) ? `N_CODE_MAX
                   : pubFf.bytes[2][2:0];
  assign nMask   = 5'h1F >> (3'h5 - nCode);
  assign drawR   = (prngFf[4:0] & nMask) + 5'h01;
  assign afiHit  = pubFf.bytes[1] == 8'h00 || pubFf.bytes[1] == ownAfi;
  assign open    = stateFf == typeb_ac_pkg::ST_IDLE
                   || stateFf == typeb_ac_pkg::ST_READY;
  // wake-up joins from halt, plain request only from idle/ready
  assign joinReq = isReq && afiHit && stateFf != typeb_ac_pkg::ST_ACTIVE
                   && (isWake || stateFf != typeb_ac_pkg::ST_HALT);
  assign isSlot  = ok && b0[3:0] == `SLOT_NIBBLE && b0[7:4] != 4'h0
                   && pubFf.len == `LEN_SLOT;
  assign slotHit = isSlot && stateFf == typeb_ac_pkg::ST_READY
                   && {1'b0, b0[7:4]} + 5'h01 == slotFf;
  assign pupiHit = {pubFf.bytes[1], pubFf.bytes[2], pubFf.bytes[3],
                    pubFf.bytes[4]} == ownPupi;
  assign haltHit = ok && open && b0 == `CMD_HALT
                   && pubFf.len == `LEN_HALT && pupiHit;
  assign attrHit = ok && open && b0 == `CMD_ATTRIB
                   && pubFf.len == `LEN_ATTRIB && pupiHit;
  assign deselHit = ok && stateFf == typeb_ac_pkg::ST_ACTIVE
    && ((b0 == `CMD_DESEL && pubFf.len == `LEN_DESEL && cidFf == 4'h0)
    || (b0 == `CMD_DESEL_CID && pubFf.len == `LEN_DESEL_CID
        && pubFf.bytes[1][3:0] == cidFf));

  // card state, slot, answer and random source
  always_comb
  begin
    nxtState  = stateFf;
    nxtSlot   = slotFf;
    nxtCid    = cidFf;
    nxtRsp    = rspFf;
    nxtRspTog = rspTogFf;
    nxtPrng   = {prngFf[14:0], prngFf[15] ^ prngFf[13] ^ prngFf[12]
                 ^ prngFf[10]};
    if (joinReq)
    begin
      nxtState = typeb_ac_pkg::ST_READY;
      nxtSlot  = drawR;
    end
    if ((joinReq && drawR == 5'h01) || slotHit)
    begin
      nxtRsp.bytes = {ownPupi[7:0], ownPupi[15:8], ownPupi[23:16],
                      ownPupi[31:24], `RSP_ATQB};
      nxtRsp.len   = 3'h5;
      nxtRspTog    = ~rspTogFf;
    end
    else if (haltHit)
    begin
      nxtState     = typeb_ac_pkg::ST_HALT;
      nxtRsp.bytes = {32'h0000_0000, `RSP_HALT};
      nxtRsp.len   = 3'h1;
      nxtRspTog    = ~rspTogFf;
    end
    else if (attrHit)
    begin
      nxtState     = typeb_ac_pkg::ST_ACTIVE;
      nxtCid       = pubFf.bytes[8][3:0];
      nxtRsp.bytes = {32'h0000_0000, 4'h0, pubFf.bytes[8][3:0]};
      nxtRsp.len   = 3'h1;
      nxtRspTog    = ~rspTogFf;
    end
    else if (deselHit)
    begin
      nxtState     = typeb_ac_pkg::ST_HALT;
      nxtRsp.bytes = pubFf.bytes[4:0];
      nxtRsp.len   = 3'(pubFf.len - 4'h2);
      nxtRspTog    = ~rspTogFf;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      stateFf  <= typeb_ac_pkg::ST_IDLE;
      slotFf   <= 5'h00;
      cidFf    <= 4'h0;
      rspFf    <= '0;
      rspTogFf <= 1'b0;
      prngFf   <= `PRNG_SEED;
    end
    else
    begin
      stateFf  <= nxtState;
      slotFf   <= nxtSlot;
      cidFf    <= nxtCid;
      rspFf    <= nxtRsp;
      rspTogFf <= nxtRspTog;
      prngFf   <= nxtPrng;
    end
  end
  assign cardState = stateFf;
  assign cardCid   = cidFf;

  ////////////////////////////////////////////////////////////////////////////
  // eight-bit check generator

  logic [7:0] crc8Ff, nxtCrc8;
  logic       crc8Fb;
  assign crc8Fb = crc8Ff[0] ^ crc8Bit;
  always_comb
  begin
    nxtCrc8 = crc8Ff;
    if (crc8Clear)
      nxtCrc8 = 8'h00;
    else if (crc8Shift)
      nxtCrc8 = (crc8Ff >> 1) ^ (crc8Fb ? `CRC8_POLY_R : 8'h00);
  end
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      crc8Ff <= 8'h00;
    else
      crc8Ff <= nxtCrc8;
  end
  assign crc8Value = crc8Ff;

  ////////////////////////////////////////////////////////////////////////////
  // link transmitter: body bits, then inverted check LSb first

  typeb_ac_pkg::tx_t txStFf, nxtTxSt;
  logic [2:0]  bitFf, nxtBit, byteFf, nxtByte;
  logic [3:0]  txCntFf, nxtTxCnt;
  logic [15:0] txCrcFf, nxtTxCrc, shFf, nxtSh;
  logic        txBitFf, nxtTxBit;
  always_comb
  begin
    nxtTxSt  = txStFf;
    nxtBit   = bitFf;
    nxtByte  = byteFf;
    nxtTxCnt = txCntFf;
    nxtTxCrc = txCrcFf;
    nxtSh    = shFf;
    nxtTxBit = 1'b0;
    case (txStFf)
      typeb_ac_pkg::TX_IDLE:
        if (newRsp)
        begin
          nxtTxSt  = typeb_ac_pkg::TX_DATA;
          nxtBit   = 3'h0;
          nxtByte  = 3'h0;
          nxtTxCrc = `CRC16_PRESET;
        end
      typeb_ac_pkg::TX_DATA:
      begin
        nxtTxBit = rspFf.bytes[byteFf][bitFf];
        nxtTxCrc = crc16Bit(txCrcFf, nxtTxBit);
        nxtBit   = bitFf + 3'h1;
        if (bitFf == 3'h7)
        begin
          nxtByte = byteFf + 3'h1;
          if (byteFf == rspFf.len - 3'h1)
          begin
            nxtTxSt  = typeb_ac_pkg::TX_CRC;
            nxtSh    = ~nxtTxCrc;
            nxtTxCnt = 4'h0;
          end
        end
      end
      typeb_ac_pkg::TX_CRC:
      begin
        nxtTxBit = shFf[0];
        nxtSh    = shFf >> 1;
        nxtTxCnt = txCntFf + 4'h1;
        if (txCntFf == 4'hF)
          nxtTxSt = typeb_ac_pkg::TX_IDLE;
      end
      default:
        nxtTxSt = typeb_ac_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge linkClk or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      txStFf   <= typeb_ac_pkg::TX_IDLE;
      bitFf    <= 3'h0;
      byteFf   <= 3'h0;
      txCntFf  <= 4'h0;
      txCrcFf  <= `CRC16_PRESET;
      shFf     <= 16'h0000;
      txBitFf  <= 1'b0;
      txActive <= 1'b0;
    end
    else
    begin
      txStFf   <= nxtTxSt;
      bitFf    <= nxtBit;
      byteFf   <= nxtByte;
      txCntFf  <= nxtTxCnt;
      txCrcFf  <= nxtTxCrc;
      shFf     <= nxtSh;
      txBitFf  <= nxtTxBit;
      txActive <= txStFf != typeb_ac_pkg::TX_IDLE;
    end
  end
  assign txBit = txBitFf;

  ////////////////////////////////////////////////////////////////////////////
  // assertions and covers

  property p_halt_reqb;
    @(posedge clk_sys) disable iff (!resetn)
    stateFf == typeb_ac_pkg::ST_HALT && isReq && !isWake
    |=> stateFf == typeb_ac_pkg::ST_HALT && $stable(rspTogFf);
  endproperty
  a_halt_reqb: assert property (p_halt_reqb)
    else $error("plain request left halt");
  property p_wake_join;
    @(posedge clk_sys) disable iff (!resetn)
    isReq && isWake && afiHit && stateFf != typeb_ac_pkg::ST_ACTIVE
    |=> stateFf == typeb_ac_pkg::ST_READY;
  endproperty
  a_wake_join: assert property (p_wake_join)
    else $error("wake-up with matching family not joined");
  property p_n_one;
    @(posedge clk_sys) disable iff (!resetn)
    joinReq && nCode == 3'h0 |=> rspTogFf != $past(rspTogFf)
    && rspFf.bytes[0] == `RSP_ATQB ##[1:12] rs2Ff == rspTogFf;
  endproperty
  a_n_one: assert property (p_n_one)
    else $error("single slot request not answered");
  property p_slot_range;
    @(posedge clk_sys) disable iff (!resetn)
    joinReq |=> slotFf != 5'h00 && slotFf - 5'h01 <= $past(nMask);
  endproperty
  a_slot_range: assert property (p_slot_range)
    else $error("drawn slot out of range");
  property p_slot_one;
    @(posedge clk_sys) disable iff (!resetn)
    joinReq && drawR == 5'h01 |=> rspTogFf != $past(rspTogFf);
  endproperty
  a_slot_one: assert property (p_slot_one)
    else $error("slot one not answered at once");
  property p_marker;
    @(posedge clk_sys) disable iff (!resetn)
    isSlot && stateFf == typeb_ac_pkg::ST_READY
    |=> (rspTogFf != $past(rspTogFf)) == $past(slotHit);
  endproperty
  a_marker: assert property (p_marker)
    else $error("slot marker answer wrong");
  property p_active_quiet;
    @(posedge clk_sys) disable iff (!resetn)
    stateFf == typeb_ac_pkg::ST_ACTIVE && newFrame && !deselHit
    |=> stateFf == typeb_ac_pkg::ST_ACTIVE && $stable(rspTogFf);
  endproperty
  a_active_quiet: assert property (p_active_quiet)
    else $error("active card reacted to other command");
  property p_attrib;
    @(posedge clk_sys) disable iff (!resetn)
    attrHit |=> stateFf == typeb_ac_pkg::ST_ACTIVE
    && cidFf == $past(pubFf.bytes[8][3:0]) && rspFf.len == 3'h1;
  endproperty
  a_attrib: assert property (p_attrib)
    else $error("attrib did not activate");
  property p_desel;
    @(posedge clk_sys) disable iff (!resetn)
    deselHit |=> stateFf == typeb_ac_pkg::ST_HALT
    && rspFf.bytes[0] == $past(b0);
  endproperty
  a_desel: assert property (p_desel)
    else $error("deselect not echoed");
  property p_crc8;
    @(posedge clk_sys) disable iff (!resetn)
    crc8Shift && !crc8Clear && crc8Bit == crc8Ff[0]
    |=> crc8Ff == ($past(crc8Ff) >> 1);
  endproperty
  a_crc8: assert property (p_crc8)
    else $error("eight-bit check shift wrong");
  property p_tx_crc;
    @(posedge linkClk) disable iff (!linkRstN)
    $rose(txStFf == typeb_ac_pkg::TX_CRC) |-> shFf == ~txCrcFf
    ##1 txBitFf == ~txCrcFf[0] ##15 txStFf == typeb_ac_pkg::TX_IDLE;
  endproperty
  a_tx_crc: assert property (p_tx_crc)
    else $error("frame check not sent inverted LSb first");

  c_atqb_now: cover property (@(posedge clk_sys) joinReq && drawR == 5'h01);
  c_marker:   cover property (@(posedge clk_sys) slotHit);
  c_attrib:   cover property (@(posedge clk_sys) attrHit);
  c_desel:    cover property (@(posedge clk_sys) deselHit);
endmodule

// file: testbench/typeb_reader_model.sv
`timescale 1ns/1ps
module typeb_reader_model (
  input  wire logic       linkClk,  // link bit clock
  output logic            rxValid,  // byte strobe to card
  output logic [7:0]      rxData,   // byte to card
  output logic            rxEnd,    // end of frame to card
  input  wire logic       txBit,    // answer bit from card
  input  wire logic       txActive  // answer bit valid
);
  logic [7:0]             lastByte;

  // idle link: no strobes, data line zero at start, later the inverted last byte
  initial
  begin
    rxValid = 1'b0;
    rxEnd = 1'b0;
    rxData = 8'h00;
    lastByte = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame check over n bytes, sent inverted
  function automatic logic [15:0] crc16(input logic [11:0][7:0] b,
                                        input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++)
      for (int k = 0; k < 8; k++)
        c = (c[0] ^ b[i][k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return ~c;
  endfunction

  // one frame, check appended low byte first; bad spoils the check
  task automatic send(input logic [11:0][7:0] b, input int n,
                      input logic bad);
    logic [15:0] c;
    c = crc16(b, n) ^ {15'h0, bad};
    b[n] = c[7:0];
    b[n + 1] = c[15:8];
    for (int i = 0; i < n + 2; i++)
    begin
      @(negedge linkClk);
      rxValid = 1'b1;
      rxData = b[i];
      lastByte = b[i];
    end
    @(negedge linkClk);
    rxValid = 1'b0;
    rxData = ~lastByte;
    rxEnd = 1'b1;
    @(negedge linkClk);
    rxEnd = 1'b0;
  endtask

  // collects an answer LSb first; n is 0 when the card stays silent
  task automatic recv(output logic [11:0][7:0] a, output int n,
                      output logic ok);
    int w;
    int bits;
    a = '0;
    n = 0;
    ok = 1'b0;
    w = 0;
    bits = 0;
    while (txActive !== 1'b1 && w < 40)
    begin
      @(negedge linkClk);
      w++;
    end
    while (txActive === 1'b1 && bits < 96)
    begin
      a[bits / 8][bits % 8] = txBit;
      bits++;
      @(negedge linkClk);
    end
    if (bits >= 24)
    begin
      n = bits / 8 - 2;
      ok = (bits % 8 == 0) && ({a[n + 1], a[n]} === crc16(a, n));
    end
  endtask
endmodule

// file: testbench/typeb_anticollision_crc_tb.sv
`timescale 1ns/1ps
module typeb_anticollision_crc_tb;
  localparam logic [31:0] PUPI = 32'hC0DE_1234; // arbitrary card id
  localparam logic [7:0]  AFI  = 8'h31;         // arbitrary family
  logic                   clk_sys = 1'b0;
  logic                   linkClk = 1'b0;
  logic                   resetn = 1'b0;
  logic                   crc8Clear = 1'b0;
  logic                   crc8Shift = 1'b0;
  logic                   crc8Bit = 1'b0;
  logic                   rxValid, rxEnd, txBit, txActive;
  logic [7:0]             rxData, crc8Value;
  logic [3:0]             cardCid;
  typeb_ac_pkg::card_t    cardState;
  logic [11:0][7:0]       fr, ans;
  logic [11:0][7:0]       atqb;
  int                     ansLen;
  logic                   ansOk;
  int                     errors = 0;
  int                     comparisons = 0;
  int                     cycles = 0;

  assign atqb = {56'h0, PUPI[7:0], PUPI[15:8], PUPI[23:16], PUPI[31:24],
                 8'h50};

  // system clock, link clock at another rate and offset in phase
  always #4 clk_sys = ~clk_sys;
  initial
  begin
    #1.3;
    forever #3 linkClk = ~linkClk;
  end

  typeb_anticollision_crc dut (
    .clk_sys(clk_sys), .resetn(resetn), .linkClk(linkClk),
    .ownPupi(PUPI), .ownAfi(AFI), .rxValid(rxValid), .rxData(rxData),
    .rxEnd(rxEnd), .txBit(txBit), .txActive(txActive),
    .crc8Clear(crc8Clear), .crc8Shift(crc8Shift), .crc8Bit(crc8Bit),
    .crc8Value(crc8Value), .cardState(cardState), .cardCid(cardCid)
  );

  typeb_reader_model rdr (
    .linkClk(linkClk), .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd),
    .txBit(txBit), .txActive(txActive)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chkst(input typeb_ac_pkg::card_t got,
                       input typeb_ac_pkg::card_t exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: state %0d want %0d", $time, got, exp);
    end
  endtask

  // frame builders: three bytes, or a code followed by the card id
  task automatic setf(input logic [7:0] b0, b1, b2);
    fr = '0;
    fr[0] = b0;
    fr[1] = b1;
    fr[2] = b2;
  endtask

  task automatic setp(input logic [7:0] c);
    fr = atqb;
    fr[0] = c;
  endtask

  // send fr, expect en answer bytes e (0: silence)
  task automatic xfer(input int n, input logic bad,
                      input logic [11:0][7:0] e, input int en);
    rdr.send(fr, n, bad);
    rdr.recv(ans, ansLen, ansOk);
    chk8(8'(ansLen), 8'(en));
    if (en > 0)
      chk8({7'h0, ansOk}, 8'h01);
    for (int i = 0; i < en; i++)
      chk8(ans[i], e[i]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_crc8();
    logic [7:0]  e;
    logic [23:0] d;
    e = 8'h00;
    d = 24'hA5_3CF1;
    @(negedge clk_sys);
    crc8Clear = 1'b1;
    crc8Shift = 1'b1;
    @(negedge clk_sys);
    chk8(crc8Value, 8'h00);
    crc8Clear = 1'b0;
    for (int k = 0; k < 24; k++)
    begin
      crc8Bit = d[k];
      e = (e[0] ^ d[k]) ? (e >> 1) ^ 8'h8C : e >> 1;
      @(negedge clk_sys);
    end
    crc8Shift = 1'b0;
    chk8(crc8Value, e);
  endtask

  task automatic t_reqb();
    setf(8'h05, AFI, 8'h00);
    xfer(3, 1'b0, atqb, 5);
    chkst(cardState, typeb_ac_pkg::ST_READY);
    setf(8'h05, ~AFI, 8'h00);
    xfer(3, 1'b0, atqb, 0);
    setf(8'h05, 8'h00, 8'h00);
    xfer(3, 1'b0, atqb, 5);
    setf(8'h05, AFI, 8'h00);
    xfer(3, 1'b1, atqb, 0);
  endtask

  // slot counts 2 to 16; markers probed from the top slot down
  task automatic t_slots();
    logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    int n, hits, first, slot, diff;
    first = 0;
    diff = 0;
    slot = 0;
    for (int r = 0; r < 5; r++)
    begin
      n = 1 << ((codes[r] > 3'h4) ? 4 : codes[r]);
      hits = 0;
      for (int s = n + 1; s >= 2; s--)
      begin
        if (s > n)
          setf(8'h05, AFI, {5'h01, codes[r]});
        else
          setf({4'(s - 1), 4'h5}, 8'h00, 8'h00);
        rdr.send(fr, (s > n) ? 3 : 1, 1'b0);
        rdr.recv(ans, ansLen, ansOk);
        if (ansLen > 0)
        begin
          hits++;
          slot = (s > n) ? 1 : s;
          chk8(ans[1], PUPI[31:24]);
          chk8({7'h0, ansOk}, 8'h01);
        end
      end
      chk8(8'(hits), 8'h01);
      if (r == 0)
        first = slot;
      else if (slot != first)
        diff = 1;
    end
    chk8(8'(diff), 8'h01);
  endtask

  task automatic t_halt();
    setp(8'h50);
    xfer(5, 1'b0, '0, 1);
    chkst(cardState, typeb_ac_pkg::ST_HALT);
    setf(8'h05, AFI, 8'h00);
    xfer(3, 1'b0, atqb, 0);
    setf(8'h05, AFI, 8'h08);
    xfer(3, 1'b0, atqb, 5);
    chkst(cardState, typeb_ac_pkg::ST_READY);
  endtask

  task automatic t_active();
    setp(8'h1D);
    fr[7] = 8'h01;
    fr[8] = 8'h05;
    xfer(9, 1'b0, 96'h05, 1);
    chkst(cardState, typeb_ac_pkg::ST_ACTIVE);
    chk8({4'h0, cardCid}, 8'h05);
    setf(8'h05, AFI, 8'h00);
    xfer(3, 1'b0, atqb, 0);
    setf(8'h05, AFI, 8'h08);
    xfer(3, 1'b0, atqb, 0);
    setf(8'h15, 8'h00, 8'h00);
    xfer(1, 1'b0, atqb, 0);
    setp(8'h50);
    xfer(5, 1'b0, atqb, 0);
    setp(8'h1D);
    xfer(9, 1'b0, atqb, 0);
    chkst(cardState, typeb_ac_pkg::ST_ACTIVE);
    setf(8'hC2, 8'h00, 8'h00);
    xfer(1, 1'b0, fr, 0);
    setf(8'hCA, 8'h04, 8'h00);
    xfer(2, 1'b0, fr, 0);
    setf(8'hCA, 8'h05, 8'h00);
    xfer(2, 1'b0, fr, 2);
    chkst(cardState, typeb_ac_pkg::ST_HALT);
    setf(8'h05, AFI, 8'h08);
    xfer(3, 1'b0, atqb, 5);
    setp(8'h1D);
    fr[7] = 8'h01;
    xfer(9, 1'b0, 96'h00, 1);
    setf(8'hC2, 8'h00, 8'h00);
    xfer(1, 1'b0, fr, 1);
    chkst(cardState, typeb_ac_pkg::ST_HALT);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      stop_test();
    end
  end

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    repeat (4) @(negedge linkClk);
    chkst(cardState, typeb_ac_pkg::ST_IDLE);
    chk8({7'h0, txActive}, 8'h00);
    t_crc8();
    t_reqb();
    t_slots();
    t_halt();
    t_active();
    stop_test();
  end
endmodule
